// File: design/cfg_word_two_pkg.sv
// package for the second configuration word decoder
// assumes a 14-bit word, one 40 MHz clock domain, synchronous active-low reset
package cfg_word_two_pkg;

    // ****************************************************************
    // register map and field positions
    // ****************************************************************
    localparam logic [3:0]  ADDR_CONFIG_WORD  = 4'h0;  // config word value
    localparam logic [3:0]  ADDR_PROT_STATUS  = 4'h1;  // decoded protect bounds
    localparam logic [3:0]  ADDR_ARRAY_SIZE   = 4'h2;  // array size select
    localparam int          WORD_WIDTH        = 14;
    localparam int          POS_LOW_VOLTAGE   = 13;
    localparam int          POS_DEBUG_OFF     = 12;
    localparam int          POS_BROWNOUT      = 10;
    localparam int          POS_STACK_RESET   = 9;
    localparam int          POS_PLL           = 8;
    localparam int          POS_RESERVED      = 4;
    localparam int          POS_PROTECT       = 0;
    // writable bits: 13,12,10,9,8,1,0 (reserved bit 4 writable, must be 1)
    localparam logic [13:0] WRITABLE_MASK     = 14'h3713;
    // unimplemented bits 11, 7-5, 3-2 read as one
    localparam logic [13:0] UNIMPL_ONES       = 14'h08ec;
    // erased (factory) value: all ones
    localparam logic [13:0] RESET_WORD        = 14'h3fff;
    localparam logic [11:0] ADDR_TOP_2K       = 12'h7ff;
    localparam logic [11:0] ADDR_TOP_4K       = 12'hfff;
    localparam logic [11:0] BOUND_512         = 12'h200;
    localparam logic [11:0] BOUND_1K          = 12'h400;
    localparam logic [11:0] BOUND_2K          = 12'h800;

endpackage

// File: design/config_word_two_decoder.sv
// second configuration word: storage, read-back and decoded control outputs
// assumes the programmer writes the word over a plain register port
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module config_word_two_decoder
(
    input  wire logic        clk,            // 40 MHz clock
    input  wire logic        rst_n,          // synchronous reset, active low
    input  wire logic [3:0]  regAddr,        // register address
    input  wire logic [13:0] regWdata,       // write data
    input  wire logic        regWrite,       // write strobe
    input  wire logic        regRead,        // read strobe
    output logic      [13:0] regRdata,       // read data, cycle after strobe
    input  wire logic        hvOnMasterClear,// high voltage on master-clear pin
    input  wire logic        lvKeyMatched,   // low-voltage entry key seen
    input  wire logic        stackFault,     // stack overflow/underflow pulse
    input  wire logic [11:0] selfWriteAddr,  // self-write target address
    output logic             progEntry,      // programming mode entry granted
    output logic             debugPinsOwned, // debugger owns programming pins
    output logic             brownoutLowTrip,// lower brown-out threshold chosen
    output logic             stackReset,     // reset request from stack fault
    output logic             pllEnable,      // four-times multiplier on
    output logic             selfWriteAllow  // self-write address not protected
);

    // ****************************************************************
    // stored word and decode
    // ****************************************************************
    logic [13:0] cfgWord;
    logic        array4k;
    logic [11:0] firstWritable;
    logic        allProtected;

    // stored bits plus forced ones in unimplemented positions
    wire logic [13:0] readWord  = cfgWord | cfg_word_two_pkg::UNIMPL_ONES;
    wire logic [13:0] next_word = (regWdata & cfg_word_two_pkg::WRITABLE_MASK)
                                | cfg_word_two_pkg::UNIMPL_ONES;
    wire logic        wrCfg     = regWrite && regAddr == cfg_word_two_pkg::ADDR_CONFIG_WORD;
    wire logic        wrSize    = regWrite && regAddr == cfg_word_two_pkg::ADDR_ARRAY_SIZE;
    wire logic [11:0] topAddr   = array4k ? cfg_word_two_pkg::ADDR_TOP_4K
                                          : cfg_word_two_pkg::ADDR_TOP_2K;
    wire logic        addrOk    = !allProtected && selfWriteAddr >= firstWritable
                                && selfWriteAddr <= topAddr;
    wire logic        lvEnabled = cfgWord[cfg_word_two_pkg::POS_LOW_VOLTAGE];
    wire logic        next_entry = hvOnMasterClear || (lvEnabled && lvKeyMatched);

    // read mux; unmapped addresses read zero
    wire logic [13:0] next_rdata =
        !regRead ? 14'h0000 :
        regAddr == cfg_word_two_pkg::ADDR_CONFIG_WORD ? readWord :
        regAddr == cfg_word_two_pkg::ADDR_PROT_STATUS ? {1'b0, allProtected, firstWritable} :
        regAddr == cfg_word_two_pkg::ADDR_ARRAY_SIZE  ? {13'h0000, array4k} : 14'h0000;

    protect_range_decode u_protect
    (
        .protField     (cfgWord[1:0]),
        .array4k       (array4k),
        .firstWritable (firstWritable),
        .allProtected  (allProtected)
    );

    // word storage; reserved bit 4 taken as written by the programmer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfgWord <= cfg_word_two_pkg::RESET_WORD;
            array4k <= 1'b0;
        end
        else
        begin
            if (wrCfg)
                cfgWord <= next_word;
            if (wrSize)
                array4k <= regWdata[0];
        end
    end

    // registered outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            regRdata        <= 14'h0000;
            progEntry       <= 1'b0;
            debugPinsOwned  <= 1'b0;
            brownoutLowTrip <= 1'b1;
            stackReset      <= 1'b0;
            pllEnable       <= 1'b0;
            selfWriteAllow  <= 1'b0;
        end
        else
        begin
            regRdata        <= next_rdata;
            progEntry       <= next_entry;
            debugPinsOwned  <= !cfgWord[cfg_word_two_pkg::POS_DEBUG_OFF];
            brownoutLowTrip <= cfgWord[cfg_word_two_pkg::POS_BROWNOUT];
            stackReset      <= stackFault && cfgWord[cfg_word_two_pkg::POS_STACK_RESET];
            pllEnable       <= cfgWord[cfg_word_two_pkg::POS_PLL];
            selfWriteAllow  <= addrOk;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_lv_entry;
        @(posedge clk) disable iff (!rst_n)
        (lvKeyMatched && !hvOnMasterClear && !lvEnabled) |=> !progEntry;
    endproperty
    a_lv_entry: assert property (p_lv_entry) else $error("entry without high voltage");

    property p_hv_entry;
        @(posedge clk) disable iff (!rst_n) hvOnMasterClear |=> progEntry;
    endproperty
    a_hv_entry: assert property (p_hv_entry) else $error("high voltage entry refused");

    property p_debug;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> debugPinsOwned == !$past(cfgWord[cfg_word_two_pkg::POS_DEBUG_OFF]);
    endproperty
    a_debug: assert property (p_debug) else $error("debugger pin ownership wrong");

    property p_brownout;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> brownoutLowTrip == $past(cfgWord[cfg_word_two_pkg::POS_BROWNOUT]);
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out select wrong");

    property p_stack;
        @(posedge clk) disable iff (!rst_n)
        stackFault |=> stackReset == $past(cfgWord[9]);
    endproperty
    a_stack: assert property (p_stack) else $error("stack fault reset wrong");

    property p_pll;
        @(posedge clk) disable iff (!rst_n)
        rst_n |=> pllEnable == $past(cfgWord[cfg_word_two_pkg::POS_PLL]);
    endproperty
    a_pll: assert property (p_pll) else $error("pll enable wrong");

    sequence s_protect_low;
        !array4k && cfgWord[1:0] == 2'h1 && selfWriteAddr == 12'h3ff;
    endsequence
    property p_prot2k;
        @(posedge clk) disable iff (!rst_n) s_protect_low |=> !selfWriteAllow;
    endproperty
    a_prot2k: assert property (p_prot2k) else $error("2K protect range wrong");

    property p_prot4k;
        @(posedge clk) disable iff (!rst_n)
        (array4k && cfgWord[1:0] == 2'h1 && selfWriteAddr == 12'h800) |=> selfWriteAllow;
    endproperty
    a_prot4k: assert property (p_prot4k) else $error("4K protect range wrong");

    property p_unimpl;
        @(posedge clk) disable iff (!rst_n)
        (regRead && regAddr == 4'h0) |=> (regRdata & 14'h08ec) == 14'h08ec;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not one");

    // ****************************************************************
    // further assertions: quiet outputs, range ends, word storage
    // ****************************************************************
    property p_lv_grant;
        @(posedge clk) disable iff (!rst_n)
        (lvKeyMatched && lvEnabled) |=> progEntry;
    endproperty
    a_lv_grant: assert property (p_lv_grant) else $error("key entry refused");

    property p_stack_quiet;
        @(posedge clk) disable iff (!rst_n) !stackFault |=> !stackReset;
    endproperty
    a_stack_quiet: assert property (p_stack_quiet) else $error("stray stack reset");

    sequence s_field_none_2k;
        !array4k && cfgWord[1:0] == 2'h3 && selfWriteAddr == 12'h000;
    endsequence
    property p_prot_none;
        @(posedge clk) disable iff (!rst_n) s_field_none_2k |=> selfWriteAllow;
    endproperty
    a_prot_none: assert property (p_prot_none) else $error("write refused");

    property p_prot_all;
        @(posedge clk) disable iff (!rst_n)
        (!array4k && cfgWord[1:0] == 2'h0) |=> !selfWriteAllow;
    endproperty
    a_prot_all: assert property (p_prot_all) else $error("protected write allowed");

    property p_prot_1ff;
        @(posedge clk) disable iff (!rst_n)
        (cfgWord[1:0] == 2'h2 && selfWriteAddr == 12'h1ff) |=> !selfWriteAllow;
    endproperty
    a_prot_1ff: assert property (p_prot_1ff) else $error("block open");

    property p_prot_200;
        @(posedge clk) disable iff (!rst_n)
        (cfgWord[1:0] == 2'h2 && selfWriteAddr == 12'h200) |=> selfWriteAllow;
    endproperty
    a_prot_200: assert property (p_prot_200) else $error("block shut");

    property p_top2k;
        @(posedge clk) disable iff (!rst_n)
        (!array4k && selfWriteAddr > cfg_word_two_pkg::ADDR_TOP_2K) |=> !selfWriteAllow;
    endproperty
    a_top2k: assert property (p_top2k) else $error("beyond array allowed");

    sequence s_word_written;
        regWrite && regAddr == cfg_word_two_pkg::ADDR_CONFIG_WORD;
    endsequence
    property p_word_keep;
        @(posedge clk) disable iff (!rst_n) s_word_written |=>
        (cfgWord & cfg_word_two_pkg::UNIMPL_ONES) == cfg_word_two_pkg::UNIMPL_ONES
        && (cfgWord & cfg_word_two_pkg::WRITABLE_MASK)
           == ($past(regWdata) & cfg_word_two_pkg::WRITABLE_MASK);
    endproperty
    a_word_keep: assert property (p_word_keep) else $error("word stored wrong");

endmodule // config_word_two_decoder
`default_nettype wire

// File: design/protect_range_decode.sv
// decodes the self-write protect field into the first writable address
// assumes a purely combinational use inside the config word decoder
`timescale 1ns/100ps
`default_nettype none

module protect_range_decode
(
    input  wire logic [1:0]  protField,     // self_write_protect_hi/lo
    input  wire logic        array4k,       // 1 = 4K-word array, 0 = 2K-word
    output logic      [11:0] firstWritable, // lowest self-writable address
    output logic             allProtected   // no address self-writable
);

    // ****************************************************************
    // field decode per array size
    // ****************************************************************
    wire logic [11:0] bound01 = array4k ? cfg_word_two_pkg::BOUND_2K
                                        : cfg_word_two_pkg::BOUND_1K;

    // 11 none, 10 to 1FFh, 01 to 3FFh/7FFh, 00 all
    always_comb
    begin
        allProtected = 1'b0;
        case (protField)
            2'h3:    firstWritable = 12'h000;
            2'h2:    firstWritable = cfg_word_two_pkg::BOUND_512;
            2'h1:    firstWritable = bound01;
            default:
            begin
                firstWritable = 12'h000;
                allProtected  = 1'b1;
            end
        endcase
    end

endmodule // protect_range_decode
`default_nettype wire

// File: verif/serial_programmer.sv
// model of the external programmer that loads the configuration word
// assumes a plain register port sampled on the rising clock edge
`timescale 1ns/100ps
`default_nettype none

module serial_programmer
(
    input  wire logic        clk,      // bus clock
    output logic      [3:0]  regAddr,  // register address
    output logic      [13:0] regWdata, // write data
    output logic             regWrite, // write strobe
    output logic             regRead,  // read strobe
    input  wire logic [13:0] regRdata  // read data, cycle after strobe
);
    // bus idle at time zero
    initial
    begin
        regAddr = 4'h0;
        regWdata = 14'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // one-cycle write; released data bus shows the inverse of the last value
    task automatic write_reg(input logic [3:0] a, input logic [13:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask
    // reserved bit is always sent as one
    task automatic write_word(input logic [13:0] d);
        write_reg(cfg_word_two_pkg::ADDR_CONFIG_WORD, d | 14'h0010);
    endtask
    // one-cycle read; data taken in the cycle after the strobe
    task automatic read_reg(input logic [3:0] a, output logic [13:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
endmodule // serial_programmer
`default_nettype wire

// File: verif/test_config_word_two_decoder.sv
// bench for the second configuration word decoder
// assumes the programmer model drives the register port
`timescale 1ns/100ps
`default_nettype none
`define CHECK(a, b) begin nChecks++; if ((a) !== (b)) begin nErrors++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end

module test_config_word_two_decoder;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  regAddr;
    logic [13:0] regWdata, regRdata, rd, w;
    logic        regWrite, regRead, hv = 1'b0, key = 1'b0, fault = 1'b0;
    logic [11:0] swAddr = 12'h000, first, a;
    logic        progEntry, debugPinsOwned, brownoutLowTrip, stackReset, pllEnable, allow;
    logic        big, allProt;
    int          nErrors = 0, nChecks = 0, seed = 32'h8ef5fdb9;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    config_word_two_decoder u_config_word_two_decoder (.clk(clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .hvOnMasterClear(hv), .lvKeyMatched(key), .stackFault(fault),
        .selfWriteAddr(swAddr), .progEntry(progEntry), .debugPinsOwned(debugPinsOwned),
        .brownoutLowTrip(brownoutLowTrip), .stackReset(stackReset), .pllEnable(pllEnable),
        .selfWriteAllow(allow));
    serial_programmer u_serial_programmer (.clk(clk), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));

    // counts, verdict and end of run
    task automatic complete_run;
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog against a hung bus
    initial
    begin
        repeat (5000) @(posedge clk);
        nErrors++;
        complete_run;
    end

    // reset, then random words over every protect code and both array sizes
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        u_serial_programmer.read_reg(cfg_word_two_pkg::ADDR_CONFIG_WORD, rd);
        `CHECK(rd, cfg_word_two_pkg::RESET_WORD)
        u_serial_programmer.read_reg(4'h3, rd);
        `CHECK(rd, 14'h0000)
        $display("test reset done");
        for (int i = 0; i < 48; i++)
        begin
            w = 14'($random(seed));
            w[1:0] = i[1:0];
            big = i[2];
            u_serial_programmer.write_word(w);
            u_serial_programmer.write_reg(cfg_word_two_pkg::ADDR_ARRAY_SIZE, {13'h0000, big});
            first = (w[1:0] == 2'b11) ? 12'h000 : (w[1:0] == 2'b10) ? 12'h200
                  : big ? 12'h800 : 12'h400;
            allProt = (w[1:0] == 2'b00);
            a = (i % 3 == 0) ? first : (i % 3 == 1) ? first - 12'h001 : 12'($random(seed));
            @(posedge clk);
            hv <= 1'($random(seed));
            key <= 1'($random(seed));
            fault <= 1'($random(seed));
            swAddr <= a;
            repeat (2) @(posedge clk);
            #1;
            `CHECK(progEntry, hv | (w[13] & key))
            `CHECK(debugPinsOwned, ~w[12])
            `CHECK(brownoutLowTrip, w[10])
            `CHECK(stackReset, fault & w[9])
            `CHECK(pllEnable, w[8])
            `CHECK(allow, !allProt && a >= first && a <= (big ? 12'hfff : 12'h7ff))
            u_serial_programmer.read_reg(cfg_word_two_pkg::ADDR_CONFIG_WORD, rd);
            `CHECK(rd, (w & cfg_word_two_pkg::WRITABLE_MASK) | 14'h08fc)
            u_serial_programmer.read_reg(cfg_word_two_pkg::ADDR_PROT_STATUS, rd);
            `CHECK(rd, ({1'b0, allProt, (allProt ? 12'h000 : first)}))
            u_serial_programmer.read_reg(cfg_word_two_pkg::ADDR_ARRAY_SIZE, rd);
            `CHECK(rd, ({13'h0000, big}))
        end
        $display("test decode done");
        complete_run;
    end
endmodule // test_config_word_two_decoder
`default_nettype wire
